// [bench/adc_model.sv]
// Converter model answering start pulses, alternately prompt and slow
`timescale 1ns/100ps
`default_nettype none

module adc_model (
    input wire logic             core_clk,
    input wire logic             conv_start,
    input wire logic [2:0]       conv_chan,
    input wire logic [4:0][7:0]  chan_val,
    output var logic [7:0]       conv_result,
    output var logic             conv_done
);
    logic slow; // Selects the long answer delay

    // Answer each start within the slot
    initial begin
        conv_result = 8'h00;
        conv_done   = 1'b0;
        slow        = 1'b0;
        forever begin
            @(negedge core_clk);
            if (conv_start) begin
                repeat (slow ? 7 : 1) @(negedge core_clk);
                conv_result = chan_val[conv_chan];
                conv_done   = 1'b1;
                @(negedge core_clk);
                conv_done   = 1'b0;
                conv_result = ~conv_result;
                slow        = ~slow;
            end
        end
    end
endmodule : adc_model

`default_nettype wire

// [bench/limit_alert_sva.sv]
// Port assertions of the limit and alert block
`timescale 1ns/100ps
`default_nettype none

module limit_alert_sva (
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire limit_alert_pkg::reg_req_t reg_req,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      conv_start,
    input wire logic [2:0]                conv_chan,
    input wire logic                      alert5_out,
    input wire logic                      alert5_oe,
    input wire logic                      alert9_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] last_q; // Channel of the previous start
    logic [2:0] last_d;
    logic       en5_q;  // Pin 5 alert was ever enabled
    logic       en5_d;
    logic       en9_q;  // Pin 9 alert was ever selected
    logic       en9_d;

    // Track last channel and alert enables
    always_comb begin
        last_d = conv_start ? conv_chan : last_q;
        en5_d  = en5_q | (reg_req.wr && reg_req.addr == 8'h78 && reg_req.wdata[0]);
        en9_d  = en9_q | (reg_req.wr && reg_req.addr == 8'h7D && reg_req.wdata[1:0] == 2'h2);
    end

    // Register helper state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 3'h4;
            en5_q  <= 1'b0;
            en9_q  <= 1'b0;
        end else begin
            last_q <= last_d;
            en5_q  <= en5_d;
            en9_q  <= en9_d;
        end
    end

    sequence s_start;
        conv_start;
    endsequence
    sequence s_rd_unmapped;
        reg_req.rd && reg_req.addr == 8'h30;
    endsequence

    property p_chan_range;  s_start |-> conv_chan <= 3'h4; endproperty
    property p_chan_order;
        s_start |-> conv_chan == ((last_q == 3'h4) ? 3'h0 : last_q + 3'h1);
    endproperty
    property p_chan_hold;   $changed(conv_chan) |-> conv_start; endproperty
    property p_start_gap;   s_start |=> !conv_start [*8]; endproperty
    property p_unmapped;    s_rd_unmapped |=> reg_rdata == 8'h00; endproperty
    property p_rdata_hold;  !reg_req.rd |=> $stable(reg_rdata); endproperty
    property p_alert5_off;  !en5_q |-> !alert5_oe; endproperty
    property p_alert9_off;  !en9_q |-> !alert9_oe; endproperty
    property p_out_low;     alert5_out == 1'b0; endproperty

    a_chan_range: assert property (p_chan_range) else $error("channel out of range");
    a_chan_order: assert property (p_chan_order) else $error("channel order broken");
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid slot");
    a_start_gap: assert property (p_start_gap) else $error("starts too close");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_alert5_off: assert property (p_alert5_off) else $error("pin 5 alert early");
    a_alert9_off: assert property (p_alert9_off) else $error("pin 9 alert early");
    a_out_low: assert property (p_out_low) else $error("alert level not low");
endmodule : limit_alert_sva

bind limit_compare_alert_status limit_alert_sva limit_alert_sva_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_chan(conv_chan), .alert5_out(alert5_out),
    .alert5_oe(alert5_oe), .alert9_oe(alert9_oe));

`default_nettype wire

// [bench/testbench.sv]
// Self-checking testbench of the limit and alert block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam int AVG = 100; // Shortened averaged cycle
    localparam int FAST = 50; // Shortened fast cycle
    localparam int WAITC = 2 * (AVG + 5) + 10; // Two full cycles
    logic core_clk, rst_n, conv_done, conv_start, fan_manual;
    logic alert5_out, alert5_oe, alert9_out, alert9_oe;
    logic [7:0] reg_rdata, conv_result;
    logic [2:0] conv_chan;
    logic [3:0][15:0] fan_fan_speed_pulse;
    logic [4:0][7:0] chan_val;
    limit_alert_pkg::reg_req_t reg_req;
    limit_alert_pkg::ext_flags_t ext_flags;
    int err_count, comparisons, cyc;

    limit_compare_alert_status #(.CYCLE_AVG_CLKS(AVG), .CYCLE_FAST_CLKS(FAST))
        limit_compare_alert_status_i (.core_clk(core_clk), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_result(conv_result),
        .conv_done(conv_done), .conv_start(conv_start), .conv_chan(conv_chan),
        .fan_fan_speed_pulse(fan_fan_speed_pulse), .fan_manual(fan_manual), .ext_flags(ext_flags),
        .alert5_out(alert5_out), .alert5_oe(alert5_oe),
        .alert9_out(alert9_out), .alert9_oe(alert9_oe));
    adc_model adc_model_i (.core_clk(core_clk), .conv_start(conv_start),
        .conv_chan(conv_chan), .chan_val(chan_val), .conv_result(conv_result),
        .conv_done(conv_done));

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wt

    // One write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge core_clk);
        reg_req.wr = 1'b0;
    endtask : wr

    // One read strobe, then compare the answer
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge core_clk);
        reg_req.rd = 1'b0;
        @(negedge core_clk);
        chk8(reg_rdata, exp);
    endtask : rchk

    // Cycles between two starts of channel 0
    task automatic period(input int exp);
        int n;
        while (!(conv_start && conv_chan == 3'h0)) @(negedge core_clk);
        @(negedge core_clk);
        n = 1;
        while (!(conv_start && conv_chan == 3'h0)) begin
            n++;
            @(negedge core_clk);
        end
        chk8(8'(n), 8'(exp));
    endtask : period

    task automatic t_reset();
        chk1(alert5_oe, 1'b0);
        chk1(alert9_oe, 1'b0);
        rchk(8'h40, 8'h01);
        rchk(8'h30, 8'h00);
        wt(WAITC);
        rchk(8'h41, 8'h06);
        rchk(8'h41, 8'h00);
        rchk(8'h42, 8'h00);
    endtask : t_reset

    task automatic t_limits();
        wr(8'h47, 8'h80);
        wr(8'h48, 8'h40);
        wr(8'h4E, 8'h90);
        wr(8'h51, 8'h05);
        wr(8'h53, 8'h10);
        chan_val = {8'h10, 8'h10, 8'h90, 8'h40, 8'h81};
        wt(WAITC);
        rchk(8'h41, 8'h36);
        rchk(8'h20, 8'h81);
        wr(8'h78, 8'h01);
        wt(3);
        chk1(alert5_oe, 1'b1);
        chan_val = {8'h10, 8'h10, 8'h10, 8'h80, 8'h80};
        wt(WAITC);
        rchk(8'h41, 8'h36);
        rchk(8'h41, 8'h20);
        wr(8'h74, 8'h22);
        chan_val[0] = 8'h81;
        wt(WAITC);
        chk1(alert5_oe, 1'b0);
        // Host masks, polls status, then unmasks
        rchk(8'h41, 8'h22);
        wr(8'h51, 8'h7F);
        chan_val[0] = 8'h80;
        wt(WAITC);
        wr(8'h74, 8'h00);
        wt(3);
        chk1(alert5_oe, 1'b1);
        rchk(8'h41, 8'h22);
        wt(3);
        chk1(alert5_oe, 1'b0);
    endtask : t_limits

    task automatic t_status2();
        ext_flags = '{diode_fault: 2'h3, overtemp_event: 1'b1, overtemp_signal_timer_over: 1'b1};
        fan_fan_speed_pulse[0] = 16'h1001;
        wr(8'h54, 8'h00);
        wr(8'h55, 8'h10);
        wr(8'h7D, 8'h01);
        wt(4);
        rchk(8'h42, 8'hE2);
        rchk(8'h41, 8'h80);
        fan_manual = 1'b1;
        wt(4);
        rchk(8'h42, 8'hE6);
        wr(8'h7D, 8'h02);
        wt(4);
        chk1(alert9_oe, 1'b1);
        chk1(alert9_out, 1'b0);
        ext_flags = '0;
        fan_manual = 1'b0;
        wt(4);
        rchk(8'h42, 8'hE6);
        rchk(8'h42, 8'h00);
        rchk(8'h41, 8'h00);
        wt(4);
        chk1(alert9_oe, 1'b0);
    endtask : t_status2

    task automatic t_seq();
        int n;
        period(AVG);
        wr(8'h73, 8'h10);
        wt(WAITC);
        period(FAST);
        wr(8'h40, 8'h00);
        wt(WAITC);
        n = 0;
        repeat (300) begin
            @(negedge core_clk);
            n += int'(conv_start);
        end
        chk8(8'(n), 8'h00);
        wr(8'h40, 8'h01);
        repeat (20) if (!conv_start) @(negedge core_clk);
        chk1(conv_start, 1'b1);
    endtask : t_seq

    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        ext_flags = '0;
        fan_manual = 1'b0;
        fan_fan_speed_pulse = '0;
        chan_val = {8'h10, 8'h10, 8'h10, 8'h80, 8'h80};
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        wt(5);
        rst_n = 1'b1;
        t_reset();
        t_limits();
        t_status2();
        t_seq();
        conclude();
    end
endmodule : testbench

`default_nettype wire

// [hw/limit_alert_pkg.sv]
// Types shared by the limit and alert block
package limit_alert_pkg;

    // Sequencer states, Gray coded along idle -> start -> wait
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b11
    } seq_state_t;

    // Register port request from the serial bus engine
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Flags that come from outside the comparison logic
    typedef struct packed {
        logic [1:0] diode_fault;
        logic       overtemp_event;
        logic       overtemp_signal_timer_over;
    } ext_flags_t;

endpackage : limit_alert_pkg

// [hw/limit_alert_regs.svh]
// Register offsets, field positions, reset values and timing counts of the limit and alert block
`ifndef LIMIT_ALERT_REGS_SVH
`define LIMIT_ALERT_REGS_SVH

// Register offsets
`define OFS_CONFIG_FIRST   8'h40
`define OFS_STATUS_FIRST   8'h41
`define OFS_STATUS_SECOND  8'h42
`define OFS_LIMIT_FIRST    8'h46
`define OFS_LIMIT_LAST     8'h5B
`define OFS_CONFIG_SECOND  8'h73
`define OFS_MASK_FIRST     8'h74
`define OFS_MASK_SECOND    8'h75
`define OFS_CONFIG_THIRD   8'h78
`define OFS_CONFIG_FOURTH  8'h7D
`define OFS_VALUE_BASE     8'h20
`define LIMIT_COUNT        22

// Limit byte indices relative to the first limit offset
`define LIM_IDX_PROCESSOR_SUPPLY_FLAG_LO    5'd0
`define LIM_IDX_VCC_LO     5'd2
`define LIM_IDX_R1T_LO     5'd8
`define LIM_IDX_LT_LO      5'd10
`define LIM_IDX_R2T_LO     5'd12
`define LIM_IDX_FAN_BASE   5'd14

// Field positions
`define BIT_START          0
`define BIT_AVG_OFF        4
`define BIT_ALERT_EN       0
`define BIT_SUMMARY        7
`define PIN9_FN_OVERTEMP_SIGNAL      2'b01
`define PIN9_FN_ALERT      2'b10

// Reset values
`define RST_CONFIG_FIRST   8'h01
`define RST_VOLT_LO        8'h00
`define RST_VOLT_HI        8'hFF
`define RST_TEMP_LO        8'h81
`define RST_TEMP_HI        8'h7F
`define RST_FAN_LIM        8'hFF

// Timing: full cycle times in ms, converted at the 100 MHz clock rate
`define CLK_PER_MS         100000
`define CYCLE_AVG_MS       146
`define CYCLE_FAST_MS      19
`define CYCLE_AVG_CLKS     (`CYCLE_AVG_MS * `CLK_PER_MS)
`define CYCLE_FAST_CLKS    (`CYCLE_FAST_MS * `CLK_PER_MS)
`define ANALOG_CHANNELS    5

`endif

// [hw/limit_compare_alert_status.sv]
// Conversion sequencer, limit comparison, sticky status and alert output of the monitor
`include "limit_alert_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module limit_compare_alert_status #(
    parameter int CYCLE_AVG_CLKS  = `CYCLE_AVG_CLKS,
    parameter int CYCLE_FAST_CLKS = `CYCLE_FAST_CLKS,
    parameter int NUM_FANS        = 4
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire limit_alert_pkg::reg_req_t  reg_req,
    output logic [7:0]                      reg_rdata,
    input  wire logic [7:0]                 conv_result,
    input  wire logic                       conv_done,
    output logic                            conv_start,
    output logic [2:0]                      conv_chan,
    input  wire logic [NUM_FANS-1:0][15:0]  fan_fan_speed_pulse,
    input  wire logic                       fan_manual,
    input  wire limit_alert_pkg::ext_flags_t ext_flags,
    output logic                            alert5_out,
    output logic                            alert5_oe,
    output logic                            alert9_out,
    output logic                            alert9_oe
);

    // Slot length per channel, a fifth of the full cycle
    localparam int SLOT_AVG  = CYCLE_AVG_CLKS / `ANALOG_CHANNELS;
    localparam int SLOT_FAST = CYCLE_FAST_CLKS / `ANALOG_CHANNELS;
    localparam logic [2:0] LAST_CHAN = 3'(`ANALOG_CHANNELS - 1);

    // ------------------------------------------------------------------
    // Configuration and limit storage
    // ------------------------------------------------------------------
    logic [7:0] cfg1_q, cfg1_d;            // Start bit lives here
    logic [7:0] cfg2_q, cfg2_d;            // Averaging off bit
    logic [7:0] cfg3_q, cfg3_d;            // Alert enable for pin 5
    logic [7:0] cfg4_q, cfg4_d;            // Pin 9 function select
    logic [7:0] mask1_q, mask1_d;          // Alert masks, first status
    logic [7:0] mask2_q, mask2_d;          // Alert masks, second status
    logic [7:0] lim_q [`LIMIT_COUNT];      // Limit bytes
    logic [7:0] lim_d [`LIMIT_COUNT];
    logic [7:0] value_q [`ANALOG_CHANNELS];  // Latest conversion results
    logic [7:0] value_d [`ANALOG_CHANNELS];
    logic [7:0] rdata_d;                   // Next read data
    logic [4:0] lim_idx;                   // Limit byte index of the access
    logic       is_lim;                    // Access falls in limit block

    // Reset value of each limit byte
    function automatic logic [7:0] lim_reset(input int idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx >= `LIM_IDX_FAN_BASE) begin
            r = `RST_FAN_LIM;
        end else if (idx >= `LIM_IDX_R1T_LO) begin
            r = idx[0] ? `RST_TEMP_HI : `RST_TEMP_LO;
        end else begin
            r = idx[0] ? `RST_VOLT_HI : `RST_VOLT_LO;
        end
        return r;
    endfunction : lim_reset

    // ------------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------------
    logic [4:0] lo_base [`ANALOG_CHANNELS];  // Low limit index per channel
    logic [`ANALOG_CHANNELS-1:0] ana_ool;    // Analog out-of-limit
    logic [NUM_FANS-1:0]         fan_ool;    // Fan too slow, flagged only while fan_manual is high

    assign lo_base[0] = `LIM_IDX_PROCESSOR_SUPPLY_FLAG_LO;
    assign lo_base[1] = `LIM_IDX_VCC_LO;
    assign lo_base[2] = `LIM_IDX_R1T_LO;
    assign lo_base[3] = `LIM_IDX_LT_LO;
    assign lo_base[4] = `LIM_IDX_R2T_LO;

    // window check per analog channel; temperatures are signed
    genvar g;
    generate
        for (g = 0; g < `ANALOG_CHANNELS; g++) begin : g_ana
            window_compare #(.W(8), .SIGNED(g >= 2), .HAS_LOW(1'b1)) u_cmp (
                .value        (value_q[g]),
                .lim_lo       (lim_q[lo_base[g]]),
                .lim_hi       (lim_q[5'(lo_base[g] + 5'd1)]),
                .out_of_limit (ana_ool[g])
            );
        end
        // fans: single limit, free of sequence
        for (g = 0; g < NUM_FANS; g++) begin : g_fan
            logic slow;
            window_compare #(.W(16), .SIGNED(1'b0), .HAS_LOW(1'b0)) u_cmp (
                .value        (fan_fan_speed_pulse[g]),
                .lim_lo       (16'h0000),
                .lim_hi       ({lim_q[`LIM_IDX_FAN_BASE + 2*g + 1],
                                lim_q[`LIM_IDX_FAN_BASE + 2*g]}),
                .out_of_limit (slow)
            );
            assign fan_ool[g] = slow & fan_manual;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    logic [7:0] stat1_q, stat1_d;          // First status, bit 7 derived
    logic [7:0] stat2_q, stat2_d;          // Second status
    logic [7:0] stat1_view;                // First status with summary

    always_comb begin
        stat1_view = stat1_q;
        stat1_view[`BIT_SUMMARY] = |stat2_q;
    end

    assign is_lim  = (reg_req.addr >= `OFS_LIMIT_FIRST) && (reg_req.addr <= `OFS_LIMIT_LAST);
    assign lim_idx = 5'(reg_req.addr - `OFS_LIMIT_FIRST);

    // Writes to configuration, mask and limit registers; read data mux
    always_comb begin
        cfg1_d  = cfg1_q;
        cfg2_d  = cfg2_q;
        cfg3_d  = cfg3_q;
        cfg4_d  = cfg4_q;
        mask1_d = mask1_q;
        mask2_d = mask2_q;
        lim_d   = lim_q;
        rdata_d = reg_rdata;
        // Write decode
        if (reg_req.wr) begin
            if (reg_req.addr == `OFS_CONFIG_FIRST) begin
                cfg1_d = reg_req.wdata;
            end else if (reg_req.addr == `OFS_CONFIG_SECOND) begin
                cfg2_d = reg_req.wdata;
            end else if (reg_req.addr == `OFS_MASK_FIRST) begin
                mask1_d = reg_req.wdata;
            end else if (reg_req.addr == `OFS_MASK_SECOND) begin
                mask2_d = reg_req.wdata;
            end else if (reg_req.addr == `OFS_CONFIG_THIRD) begin
                cfg3_d = reg_req.wdata;
            end else if (reg_req.addr == `OFS_CONFIG_FOURTH) begin
                cfg4_d = reg_req.wdata;
            end else if (is_lim) begin
                lim_d[lim_idx] = reg_req.wdata;
            end
        end
        // Read decode; unmapped addresses read zero
        if (reg_req.rd) begin
            if (reg_req.addr == `OFS_CONFIG_FIRST) begin
                rdata_d = cfg1_q;
            end else if (reg_req.addr == `OFS_STATUS_FIRST) begin
                rdata_d = stat1_view;
            end else if (reg_req.addr == `OFS_STATUS_SECOND) begin
                rdata_d = stat2_q;
            end else if (reg_req.addr == `OFS_CONFIG_SECOND) begin
                rdata_d = cfg2_q;
            end else if (reg_req.addr == `OFS_MASK_FIRST) begin
                rdata_d = mask1_q;
            end else if (reg_req.addr == `OFS_MASK_SECOND) begin
                rdata_d = mask2_q;
            end else if (reg_req.addr == `OFS_CONFIG_THIRD) begin
                rdata_d = cfg3_q;
            end else if (reg_req.addr == `OFS_CONFIG_FOURTH) begin
                rdata_d = cfg4_q;
            end else if (is_lim) begin
                rdata_d = lim_q[lim_idx];
            end else if ((reg_req.addr >= `OFS_VALUE_BASE) &&
                         (reg_req.addr < `OFS_VALUE_BASE + 8'(`ANALOG_CHANNELS))) begin
                rdata_d = value_q[3'(reg_req.addr - `OFS_VALUE_BASE)];
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Register bank storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // monitoring starts without a host write
            cfg1_q    <= `RST_CONFIG_FIRST;
            cfg2_q    <= 8'h00;
            cfg3_q    <= 8'h00;
            cfg4_q    <= 8'h00;
            mask1_q   <= 8'h00;
            mask2_q   <= 8'h00;
            reg_rdata <= 8'h00;
            for (int i = 0; i < `LIMIT_COUNT; i++) begin
                lim_q[i] <= lim_reset(i);
            end
        end else begin
            cfg1_q    <= cfg1_d;
            cfg2_q    <= cfg2_d;
            cfg3_q    <= cfg3_d;
            cfg4_q    <= cfg4_d;
            mask1_q   <= mask1_d;
            mask2_q   <= mask2_d;
            reg_rdata <= rdata_d;
            lim_q     <= lim_d;
        end
    end

    // ------------------------------------------------------------------
    // Round-robin conversion sequencer
    // ------------------------------------------------------------------
    limit_alert_pkg::seq_state_t st_q, st_d;   // Sequencer state
    logic [31:0] slot_q, slot_d;               // Slot cycle counter
    logic [2:0]  chan_q, chan_d;               // Channel in conversion
    logic        start_d;                      // Conversion start pulse
    logic [31:0] slot_len;                     // Current slot length

    assign slot_len = cfg2_q[`BIT_AVG_OFF] ? 32'(SLOT_FAST) : 32'(SLOT_AVG);

    // Sequencer next state; fans never enter this sequence
    always_comb begin
        st_d    = st_q;
        slot_d  = slot_q;
        chan_d  = chan_q;
        start_d = 1'b0;
        value_d = value_q;
        case (st_q)
            limit_alert_pkg::ST_IDLE: begin
                chan_d = 3'd0;
                if (cfg1_q[`BIT_START]) begin
                    st_d = limit_alert_pkg::ST_START;
                end
            end
            // Launch one channel conversion
            limit_alert_pkg::ST_START: begin
                start_d = 1'b1;
                slot_d  = 32'd1;
                st_d    = limit_alert_pkg::ST_WAIT;
            end
            // Wait out the slot, storing the result when it arrives
            limit_alert_pkg::ST_WAIT: begin
                slot_d = slot_q + 32'd1;
                if (slot_q >= slot_len - 32'd1) begin
                    if (chan_q == LAST_CHAN) begin
                        chan_d = 3'd0;
                        st_d = cfg1_q[`BIT_START] ? limit_alert_pkg::ST_START
                                                  : limit_alert_pkg::ST_IDLE;
                    end else begin
                        chan_d = chan_q + 3'd1;
                        st_d   = limit_alert_pkg::ST_START;
                    end
                end
            end
            default: begin
                st_d = limit_alert_pkg::ST_IDLE;
            end
        endcase
        // result stored as soon as conversion finishes
        if (conv_done && (st_q == limit_alert_pkg::ST_WAIT)) begin
            value_d[chan_q] = conv_result;
        end
    end

    // Sequencer and value registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= limit_alert_pkg::ST_IDLE;
            slot_q     <= 32'd0;
            chan_q     <= 3'd0;
            conv_start <= 1'b0;
            conv_chan  <= 3'd0;
            for (int i = 0; i < `ANALOG_CHANNELS; i++) begin
                value_q[i] <= 8'h00;
            end
        end else begin
            st_q       <= st_d;
            slot_q     <= slot_d;
            chan_q     <= chan_d;
            conv_start <= start_d;
            // Channel output moves only together with its start pulse
            conv_chan  <= start_d ? chan_q : conv_chan;
            value_q    <= value_d;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status and alert
    // ------------------------------------------------------------------
    logic [7:0] cond1, cond2;      // Live out-of-limit conditions
    logic       rd_stat1, rd_stat2;
    logic       alert_d;
    logic       pin9_alert;

    assign rd_stat1   = reg_req.rd && (reg_req.addr == `OFS_STATUS_FIRST);
    assign rd_stat2   = reg_req.rd && (reg_req.addr == `OFS_STATUS_SECOND);
    assign pin9_alert = (cfg4_q[1:0] == `PIN9_FN_ALERT);

    always_comb begin
        cond1 = 8'h00;
        cond1[6] = ana_ool[4];
        cond1[5] = ana_ool[3];
        cond1[4] = ana_ool[2];
        cond1[2] = ana_ool[1];
        cond1[1] = ana_ool[0];
        cond2 = 8'h00;
        cond2[7] = ext_flags.diode_fault[1];
        cond2[6] = ext_flags.diode_fault[0];
        cond2[5] = (cfg4_q[1:0] == `PIN9_FN_OVERTEMP_SIGNAL) ? ext_flags.overtemp_signal_timer_over
                                                   : fan_ool[3];
        cond2[4] = fan_ool[2];
        cond2[3] = fan_ool[1];
        cond2[2] = fan_ool[0];
        cond2[1] = ext_flags.overtemp_event;
    end

    // set wins; a read clears ended causes only
    always_comb begin
        stat1_d = cond1 | (rd_stat1 ? 8'h00 : stat1_q);
        stat2_d = cond2 | (rd_stat2 ? 8'h00 : stat2_q);
        // masks gate alert only, same positions
        alert_d = |((stat1_view & ~mask1_q) | (stat2_q & ~mask2_q));
    end

    // Status and alert pin registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat1_q    <= 8'h00;
            stat2_q    <= 8'h00;
            alert5_out <= 1'b0;
            alert5_oe  <= 1'b0;
            alert9_out <= 1'b0;
            alert9_oe  <= 1'b0;
        end else begin
            stat1_q    <= stat1_d;
            stat2_q    <= stat2_d;
            alert5_out <= 1'b0;
            alert9_out <= 1'b0;
            // open-drain low on whichever pin is enabled
            alert5_oe  <= alert_d & cfg3_q[`BIT_ALERT_EN];
            alert9_oe  <= alert_d & pin9_alert;
        end
    end

endmodule : limit_compare_alert_status

`default_nettype wire

// [hw/window_compare.sv]
// Window comparator: high bound strictly above, low bound at or below
`timescale 1ns/100ps
`default_nettype none

module window_compare #(
    parameter int W       = 8,
    parameter bit SIGNED  = 1'b0,
    parameter bit HAS_LOW = 1'b1
) (
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] lim_lo,
    input  wire logic [W-1:0] lim_hi,
    output logic              out_of_limit
);

    logic above;    // Value strictly greater than high bound
    logic below;    // Value at or below low bound

    always_comb begin
        if (SIGNED) begin
            above = $signed(value) > $signed(lim_hi);
            below = $signed(value) <= $signed(lim_lo);
        end else begin
            above = value > lim_hi;
            below = value <= lim_lo;
        end
        out_of_limit = above | (HAS_LOW & below);
    end

endmodule : window_compare

`default_nettype wire
